// file: hw/qhd_defs.svh
`ifndef QHD_DEFS_SVH
`define QHD_DEFS_SVH

// register map, byte addresses
`define QHD_AW 12
`define QHD_REG_CTRL 12'h000
`define QHD_REG_STAT 12'h004
`define QHD_REG_NEXT 12'h008
`define QHD_REG_CHAR 12'h00C
`define QHD_REG_DEC 12'h010
`define QHD_PAGE 11:8
`define QHD_MEM_PAGE 4'h1
`define QHD_MEM_HI 7:6
`define QHD_MEM_WORD 5:2

// queue head store
`define QHD_IDX_W 3
`define QHD_WORD_AW 4
`define QHD_DEPTH 16

// link word fields
`define QHD_LNK_ADDR 31:5
`define QHD_LNK_ZERO 5'h00
`define QHD_LNK_TYPE 2:1
`define QHD_LNK_TERM 0

// endpoint characteristics word fields
`define QHD_EP_NAK 31:28
`define QHD_EP_CTRL 27
`define QHD_EP_MPL 26:16
`define QHD_EP_HEAD 15
`define QHD_EP_DTC 14
`define QHD_EP_SPEED 13:12
`define QHD_EP_NUM 11:8
`define QHD_EP_INACT 7
`define QHD_EP_DEV 6:0
`define QHD_MPL_MAX 11'h400

// encodings
`define QHD_OBJ_ISO 2'h0
`define QHD_OBJ_HEAD 2'h1
`define QHD_OBJ_SPLIT 2'h2
`define QHD_OBJ_SPAN 2'h3
`define QHD_SPD_FS 2'h0
`define QHD_SPD_LS 2'h1
`define QHD_SPD_HS 2'h2
`define QHD_SPD_RSVD 2'h3

// control register bits
`define QHD_CTL_START 0
`define QHD_CTL_PERIODIC 1
`define QHD_CTL_HEAD_TGL 2
`define QHD_CTL_TD_TGL 3
`define QHD_CTL_IDX 10:8

// status register bits
`define QHD_ST_BUSY 0
`define QHD_ST_DONE 1
`define QHD_ST_END 2
`define QHD_ST_FOLLOW 3
`define QHD_ST_BIG 4
`define QHD_ST_RSVD 5
`define QHD_ST_CLRACT 6
`define QHD_ST_TOGGLE 7

// reset values
`define QHD_WAIT_RST 1'h1
`define QHD_WORD_RST 32'h0000_0000

`endif

// file: hw/qhd_pkg.sv
`default_nettype none
`include "qhd_defs.svh"
package qhd_pkg;

  typedef enum logic [1:0] {
    QHD_OBJ_ISO_E = `QHD_OBJ_ISO,
    QHD_OBJ_HEAD_E = `QHD_OBJ_HEAD,
    QHD_OBJ_SPLIT_E = `QHD_OBJ_SPLIT,
    QHD_OBJ_SPAN_E = `QHD_OBJ_SPAN
  } qhd_obj_e;

  typedef enum logic [1:0] {
    QHD_SPD_FS_E = `QHD_SPD_FS,
    QHD_SPD_LS_E = `QHD_SPD_LS,
    QHD_SPD_HS_E = `QHD_SPD_HS,
    QHD_SPD_RSVD_E = `QHD_SPD_RSVD
  } qhd_speed_e;

  typedef enum logic [1:0] {
    QHD_W_IDLE, QHD_W_LINK, QHD_W_CHAR, QHD_W_DEC
  } qhd_walk_e;

  typedef enum logic [1:0] {
    QHD_B_IDLE, QHD_B_FETCH, QHD_B_ANSWER
  } qhd_bus_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [`QHD_AW-1:0] address;
    logic [31:0] writedata;
  } qhd_bus_req_s;

  typedef struct packed {
    logic [26:0] next_link_address;
    qhd_obj_e obj_type;
    logic list_end;
    logic follow;
    logic [3:0] nak_reload_count;
    logic ctrl_ep;
    logic [10:0] max_pkt;
    logic pkt_too_big;
    logic reclaim_head;
    logic toggle_from_td;
    logic init_toggle;
    qhd_speed_e endpoint_speed_code;
    logic speed_rsvd;
    logic [3:0] endpoint_number;
    logic clear_active;
    logic [6:0] dev_addr;
  } qhd_decode_s;

  typedef struct packed {
    qhd_walk_e walk;
    qhd_bus_e bus_ph;
    logic [`QHD_IDX_W-1:0] idx;
    logic periodic;
    logic head_tgl;
    logic td_tgl;
    logic done;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] link;
    logic [31:0] chr;
    qhd_decode_s dec;
  } qhd_state_s;

endpackage
`default_nettype wire

// file: hw/qhd_qh_store.sv
`default_nettype none
module qhd_head_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);
  // plain array, no reset: software fills it before any walk
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// file: hw/qhd_decoder.sv
// How it works
// [R1] link bits 31:5 give next object address, low five bits zero
// [R2] software links a queue head only to queue heads or iso descriptors; not checked here, and the test model also links to split iso and span
// [R3] software writes zero into link bits 4 and 3
// [R4] link bits 2:1 pick object type: iso, queue head, split iso, span
// [R5] periodic schedule: terminate bit one ends the list, zero is valid
// [R6] asynchronous schedule: terminate bit ignored, pointer always followed
// [R7] software keeps every reachable queue head link valid
// [R8] hardware never writes the endpoint words of a queue head
// [R9] bits 31:28 of word two are the nak reload count
// [R10] software sets control flag only for non high speed control endpoints
// [R11] bits 26:16 are max packet size, limit 0x400
// [R12] bit 15 marks head of the reclamation list
// [R13] bit 14 selects initial toggle source on overlay
// [R14] bits 13:12 give speed: full, low, high, reserved
// [R15] bits 11:8 give the endpoint number
// [R16] periodic full or low speed with bit 7 set clears active
// [R17] software never sets inactivate in async schedule or high speed
// [R18] bits 6:0 give the device address
// [R19] toggle source zero keeps queue head toggle, one takes descriptor's
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`default_nettype none
`include "qhd_defs.svh"
module qhd_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire qhd_pkg::qhd_bus_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output qhd_pkg::qhd_decode_s dec
);
  import qhd_pkg::*;

  qhd_state_s q;
  qhd_state_s d;
  logic mem_we;
  logic [`QHD_WORD_AW-1:0] mem_raddr;
  logic [31:0] mem_rdata;
  logic bus_req;
  logic mem_hit;

  function automatic logic [`QHD_WORD_AW-1:0] word_of(
    input logic [`QHD_AW-1:0] a);
    word_of = a[`QHD_MEM_WORD];
  endfunction

  function automatic logic in_store(input logic [`QHD_AW-1:0] a);
    in_store = (a[`QHD_PAGE] == `QHD_MEM_PAGE) &&
               (a[`QHD_MEM_HI] == '0);
  endfunction

  function automatic logic [`QHD_WORD_AW-1:0] head_word(
    input logic [`QHD_IDX_W-1:0] i, input logic second);
    head_word = {i, second};
  endfunction

  function automatic qhd_decode_s decode(
    input logic [31:0] lnk,
    input logic [31:0] ch,
    input logic periodic,
    input logic head_tgl,
    input logic td_tgl);
    qhd_decode_s r;
    qhd_speed_e spd;
    spd = qhd_speed_e'(ch[`QHD_EP_SPEED]);
    r.next_link_address = lnk[`QHD_LNK_ADDR]; // [R1]
    r.obj_type = qhd_obj_e'(lnk[`QHD_LNK_TYPE]); // [R4]
    r.list_end = periodic && lnk[`QHD_LNK_TERM]; // [R5]
    // async lists are circular, so the terminate bit means nothing there
    r.follow = !periodic || !lnk[`QHD_LNK_TERM]; // [R6]
    r.nak_reload_count = ch[`QHD_EP_NAK]; // [R9]
    r.ctrl_ep = ch[`QHD_EP_CTRL];
    r.max_pkt = ch[`QHD_EP_MPL]; // [R11]
    // oversize is flagged, not clipped: the value stays software's
    r.pkt_too_big = ch[`QHD_EP_MPL] > `QHD_MPL_MAX; // [R11]
    r.reclaim_head = ch[`QHD_EP_HEAD]; // [R12]
    r.toggle_from_td = ch[`QHD_EP_DTC]; // [R13]
    r.init_toggle = ch[`QHD_EP_DTC] ? td_tgl : head_tgl; // [R19]
    r.endpoint_speed_code = spd; // [R14]
    r.speed_rsvd = (spd == QHD_SPD_RSVD_E); // [R14]
    r.endpoint_number = ch[`QHD_EP_NUM]; // [R15]
    r.clear_active = periodic && ch[`QHD_EP_INACT] &&
                     (spd == QHD_SPD_FS_E || spd == QHD_SPD_LS_E); // [R16]
    r.dev_addr = ch[`QHD_EP_DEV]; // [R18]
    decode = r;
  endfunction

  function automatic logic [31:0] reg_read(
    input qhd_state_s s,
    input logic [`QHD_AW-1:0] a);
    logic [31:0] v;
    v = `QHD_WORD_RST;
    case (a)
      `QHD_REG_CTRL: begin
        v[`QHD_CTL_PERIODIC] = s.periodic;
        v[`QHD_CTL_HEAD_TGL] = s.head_tgl;
        v[`QHD_CTL_TD_TGL] = s.td_tgl;
        v[`QHD_CTL_IDX] = s.idx;
      end
      `QHD_REG_STAT: begin
        v[`QHD_ST_BUSY] = (s.walk != QHD_W_IDLE);
        v[`QHD_ST_DONE] = s.done;
        v[`QHD_ST_END] = s.dec.list_end;
        v[`QHD_ST_FOLLOW] = s.dec.follow;
        v[`QHD_ST_BIG] = s.dec.pkt_too_big;
        v[`QHD_ST_RSVD] = s.dec.speed_rsvd;
        v[`QHD_ST_CLRACT] = s.dec.clear_active;
        v[`QHD_ST_TOGGLE] = s.dec.init_toggle;
      end
      `QHD_REG_NEXT: begin
        v[`QHD_LNK_ADDR] = s.dec.next_link_address; // [R1]
        v[`QHD_LNK_TYPE] = s.dec.obj_type;
      end
      `QHD_REG_CHAR: begin
        v = s.chr;
      end
      `QHD_REG_DEC: begin
        v[`QHD_EP_NAK] = s.dec.nak_reload_count;
        v[`QHD_EP_CTRL] = s.dec.ctrl_ep;
        v[`QHD_EP_MPL] = s.dec.max_pkt;
        v[`QHD_EP_HEAD] = s.dec.reclaim_head;
        v[`QHD_EP_DTC] = s.dec.toggle_from_td;
        v[`QHD_EP_SPEED] = s.dec.endpoint_speed_code;
        v[`QHD_EP_NUM] = s.dec.endpoint_number;
        v[`QHD_EP_INACT] = s.dec.clear_active;
        v[`QHD_EP_DEV] = s.dec.dev_addr;
      end
      default: begin
        v = `QHD_WORD_RST;
      end
    endcase
    reg_read = v;
  endfunction

  assign bus_req = avs_req.read || avs_req.write;
  assign mem_hit = in_store(avs_req.address);

  qhd_head_store #(
    .WIDTH(32),
    .DEPTH(`QHD_DEPTH),
    .AW(`QHD_WORD_AW)
  ) u_store (
    .clk(clk),
    .rst_b(rst_b),
    .we(mem_we),
    .waddr(word_of(avs_req.address)),
    .wdata(avs_req.writedata),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

  always_comb begin
    d = q;
    mem_we = 1'h0;
    // the walker owns the read port; the bus is held off while it runs
    case (q.walk)
      QHD_W_LINK: mem_raddr = head_word(q.idx, 1'h0);
      QHD_W_CHAR: mem_raddr = head_word(q.idx, 1'h1);
      default: mem_raddr = word_of(avs_req.address);
    endcase

    case (q.bus_ph)
      QHD_B_IDLE: begin
        if (bus_req && q.walk == QHD_W_IDLE) begin
          d.bus_ph = QHD_B_FETCH;
        end
      end
      QHD_B_FETCH: begin
        d.bus_ph = QHD_B_ANSWER;
        d.waitreq = 1'h0;
        if (avs_req.read) begin
          d.rdata = mem_hit ? mem_rdata : reg_read(q, avs_req.address);
        end else begin
          d.rdata = `QHD_WORD_RST;
        end
      end
      QHD_B_ANSWER: begin
        d.bus_ph = QHD_B_IDLE;
        d.waitreq = `QHD_WAIT_RST;
        if (avs_req.write) begin
          if (mem_hit) begin
            // only software fills the store; the walker only reads it
            mem_we = 1'h1; // [R8]
          end else if (avs_req.address == `QHD_REG_CTRL) begin
            d.periodic = avs_req.writedata[`QHD_CTL_PERIODIC];
            d.head_tgl = avs_req.writedata[`QHD_CTL_HEAD_TGL];
            d.td_tgl = avs_req.writedata[`QHD_CTL_TD_TGL];
            d.idx = avs_req.writedata[`QHD_CTL_IDX];
            if (avs_req.writedata[`QHD_CTL_START]) begin
              d.walk = QHD_W_LINK;
              d.done = 1'h0;
            end
          end else if (avs_req.address == `QHD_REG_STAT) begin
            if (avs_req.writedata[`QHD_ST_DONE]) begin
              d.done = 1'h0;
            end
          end
        end
      end
      default: begin
        d.bus_ph = QHD_B_IDLE;
        d.waitreq = `QHD_WAIT_RST;
      end
    endcase

    // walker last, so a finishing walk beats a done clear
    case (q.walk)
      QHD_W_IDLE: begin
      end
      QHD_W_LINK: begin
        d.walk = QHD_W_CHAR;
      end
      QHD_W_CHAR: begin
        d.link = mem_rdata;
        d.walk = QHD_W_DEC;
      end
      QHD_W_DEC: begin
        d.chr = mem_rdata;
        d.dec = decode(q.link, mem_rdata, q.periodic, q.head_tgl, q.td_tgl);
        d.done = 1'h1;
        d.walk = QHD_W_IDLE;
      end
      default: begin
        d.walk = QHD_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.waitreq <= `QHD_WAIT_RST;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign dec = q.dec;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_start;
    q.bus_ph == QHD_B_ANSWER && avs_req.write && !mem_hit &&
      avs_req.address == `QHD_REG_CTRL &&
      avs_req.writedata[`QHD_CTL_START];
  endsequence

  sequence s_walk;
    q.walk == QHD_W_LINK ##1 q.walk == QHD_W_CHAR ##1
      q.walk == QHD_W_DEC ##1 (q.walk == QHD_W_IDLE && q.done);
  endsequence

  sequence s_req_taken;
    q.bus_ph == QHD_B_IDLE && bus_req && q.walk == QHD_W_IDLE;
  endsequence

  chk_walk_order: assert property (s_start |=> s_walk) // [R4]
    else $error("walk did not run link, char, decode in order");
  chk_bus_answer: assert property (s_req_taken |=> avs_waitrequest ##1
      !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not two cycles after request");
  chk_link_addr: assert property (q.walk == QHD_W_DEC |=>
      dec.next_link_address == q.link[`QHD_LNK_ADDR]) // [R1]
    else $error("next link address not taken from link bits");
  chk_obj_type: assert property (q.walk == QHD_W_DEC |=>
      dec.obj_type == q.link[`QHD_LNK_TYPE]) // [R4]
    else $error("object type not decoded from link word");
  chk_list_end: assert property (q.walk == QHD_W_DEC |=>
      dec.list_end == (q.periodic && q.link[`QHD_LNK_TERM])) // [R5]
    else $error("periodic list end wrong");
  chk_async_follow: assert property (q.walk == QHD_W_DEC &&
      !q.periodic |=> dec.follow && !dec.list_end) // [R6]
    else $error("async link not followed");
  chk_store_write: assert property (mem_we |->
      q.bus_ph == QHD_B_ANSWER && avs_req.write &&
      q.walk == QHD_W_IDLE) // [R8]
    else $error("store written outside a bus write");
  chk_nak_reload: assert property (q.walk == QHD_W_DEC |=>
      dec.nak_reload_count == $past(mem_rdata[`QHD_EP_NAK])) // [R9]
    else $error("nak reload count wrong");
  chk_pkt_limit: assert property (q.walk == QHD_W_DEC |=>
      dec.pkt_too_big == ($past(mem_rdata[`QHD_EP_MPL]) >
      `QHD_MPL_MAX)) // [R11]
    else $error("max packet limit check wrong");
  chk_reclaim_head: assert property (q.walk == QHD_W_DEC |=>
      dec.reclaim_head == $past(mem_rdata[`QHD_EP_HEAD])) // [R12]
    else $error("reclamation head flag wrong");
  chk_init_toggle: assert property (q.walk == QHD_W_DEC |=>
      dec.init_toggle == ($past(mem_rdata[`QHD_EP_DTC]) ?
      q.td_tgl : q.head_tgl)) // [R13]
    else $error("initial toggle from wrong source");
  chk_speed_code: assert property (q.walk == QHD_W_DEC |=>
      dec.endpoint_speed_code == $past(mem_rdata[`QHD_EP_SPEED])) // [R14]
    else $error("endpoint speed wrong");
  chk_ep_number: assert property (q.walk == QHD_W_DEC |=>
      dec.endpoint_number == $past(mem_rdata[`QHD_EP_NUM])) // [R15]
    else $error("endpoint number wrong");
  // judged at decode time: a later mode write must not look like a fault
  chk_clear_active: assert property (q.walk == QHD_W_DEC |=>
      dec.clear_active == (q.periodic && $past(mem_rdata[`QHD_EP_INACT]) &&
      (dec.endpoint_speed_code == QHD_SPD_FS_E ||
      dec.endpoint_speed_code == QHD_SPD_LS_E))) // [R16]
    else $error("clear active outside periodic low or full speed");
  chk_dev_addr: assert property (q.walk == QHD_W_DEC |=>
      dec.dev_addr == $past(mem_rdata[`QHD_EP_DEV])) // [R18]
    else $error("device address wrong");
endmodule
`default_nettype wire

// file: tb/qhd_sw_model.sv
`default_nettype none
// stand-in for software: a fixed set of prebuilt queue heads
module qhd_sw_model (
  input wire logic [1:0] sel,
  output logic [31:0] link_w,
  output logic [31:0] char_w
);
  timeunit 1ns;
  timeprecision 1ps;
  // links keep bits 4:3 at zero and name all four object types: iso, queue head, split iso, span
  always_comb begin
    case (sel)
      2'h0: link_w = 32'h0001_2342;
      2'h1: link_w = 32'hABCD_E001;
      2'h2: link_w = 32'h1000_0025;
      default: link_w = 32'hFFFF_FFE7;
    endcase
  end
  // control flag only on slow control ends, size never above 0x400,
  // inactivate only on heads walked as periodic full or low speed
  always_comb begin
    case (sel)
      2'h0: char_w = 32'hF400_A57F;
      2'h1: char_w = 32'h3840_4F81;
      2'h2: char_w = 32'h0808_50AA;
      default: char_w = 32'h83FF_3A55;
    endcase
  end
endmodule
`default_nettype wire

// file: tb/qhd_decoder_test.sv
`default_nettype none
module qhd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import qhd_pkg::*;
  logic clk;
  logic rst_b;
  logic avs_waitrequest;
  qhd_bus_req_s avs_req;
  logic [31:0] avs_readdata;
  logic [31:0] lw;
  logic [31:0] cw;
  logic [31:0] q;
  qhd_decode_s dec;
  logic [1:0] sel;
  int err_count;
  int tests_run;

  qhd_decoder dut_u (.clk(clk), .rst_b(rst_b), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dec(dec));
  qhd_sw_model sw_u (.sel(sel), .link_w(lw), .char_w(cw));

  always #20 clk = ~clk;

  task automatic final_report;
    $display("errors %0d in %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t word exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_dec(input qhd_decode_s e, input qhd_decode_s g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t decode exp %h got %h", $time, e, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_req.read <= !w;
    avs_req.write <= w;
    avs_req.address <= a;
    avs_req.writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      $display("mismatch %0t bus answer never came", $time);
      final_report();
    end
  endtask

  function automatic qhd_decode_s expd(input logic [31:0] l,
      input logic [31:0] c, input logic per, input logic qt,
      input logic tt);
    qhd_decode_s x;
    x = '0;
    x.next_link_address = l[31:5];
    x.obj_type = qhd_obj_e'(l[2:1]);
    x.list_end = per & l[0];
    x.follow = !per | !l[0];
    x.nak_reload_count = c[31:28];
    x.ctrl_ep = c[27];
    x.max_pkt = c[26:16];
    x.pkt_too_big = c[26:16] > 11'h400;
    x.reclaim_head = c[15];
    x.toggle_from_td = c[14];
    x.init_toggle = c[14] ? tt : qt;
    x.endpoint_speed_code = qhd_speed_e'(c[13:12]);
    x.speed_rsvd = &c[13:12];
    x.endpoint_number = c[11:8];
    x.clear_active = per & c[7] & !c[13];
    x.dev_addr = c[6:0];
    return x;
  endfunction

  task automatic t_reset;
    chk_dec('0, dec);
    chk32(32'h1, {31'h0, avs_waitrequest});
  endtask

  // unmapped space answers but keeps nothing; last store word is live
  task automatic t_unmapped;
    bus(1'b1, 12'h140, 32'hDEAD_BEEF);
    bus(1'b0, 12'h140, 32'h0);
    chk32(32'h0, q);
    bus(1'b1, 12'h13C, 32'h5A5A_A5A5);
    bus(1'b0, 12'h13C, 32'h0);
    chk32(32'h5A5A_A5A5, q);
  endtask

  task automatic walk(input logic [1:0] e, input logic [2:0] i,
      input logic per, input logic qt, input logic tt);
    qhd_decode_s x;
    logic [31:0] l;
    logic [31:0] c;
    logic [11:0] a;
    logic [31:0] s;
    int n;
    sel = e;
    #1;
    l = lw;
    c = cw;
    a = 12'h100 + 12'({i, 3'h0});
    bus(1'b1, a, l);
    bus(1'b1, a + 12'h4, c);
    bus(1'b1, 12'h000, {21'h0, i, 4'h0, tt, qt, per, 1'b1});
    n = 0;
    do begin
      bus(1'b0, 12'h004, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 20);
    if (q[1] !== 1'b1) begin
      err_count++;
      $display("mismatch %0t walk never finished", $time);
      final_report();
    end
    x = expd(l, c, per, qt, tt);
    chk_dec(x, dec);
    s = {24'h0, x.init_toggle, x.clear_active, x.speed_rsvd,
      x.pkt_too_big, x.follow, x.list_end, 2'h0};
    chk32(s | 32'h2, q);
    bus(1'b0, 12'h000, 32'h0);
    chk32({21'h0, i, 4'h0, tt, qt, per, 1'h0}, q);
    bus(1'b0, 12'h008, 32'h0);
    chk32({l[31:5], 2'h0, l[2:1], 1'b0}, q);
    bus(1'b0, 12'h010, 32'h0);
    chk32({x.nak_reload_count, x.ctrl_ep, x.max_pkt, x.reclaim_head,
      x.toggle_from_td, x.endpoint_speed_code, x.endpoint_number,
      x.clear_active, x.dev_addr}, q);
    bus(1'b0, 12'h00C, 32'h0);
    chk32(c, q);
    bus(1'b0, a, 32'h0);
    chk32(l, q);
    bus(1'b0, a + 12'h4, 32'h0);
    chk32(c, q);
    // done is sticky until software writes one to it
    bus(1'b1, 12'h004, 32'h2);
    bus(1'b0, 12'h004, 32'h0);
    chk32(s, q);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    avs_req = '0;
    sel = 2'h0;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_unmapped();
    // toggles chosen so the kept and the taken value always differ
    walk(2'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    walk(2'h1, 3'h7, 1'b1, 1'b0, 1'b1);
    walk(2'h2, 3'h3, 1'b1, 1'b1, 1'b0);
    walk(2'h3, 3'h5, 1'b1, 1'b0, 1'b1);
    walk(2'h3, 3'h5, 1'b0, 1'b1, 1'b0);
    walk(2'h0, 3'h1, 1'b1, 1'b0, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
